// ---- rtl/srs_pkg.sv ----
package srs_pkg;
  typedef enum logic [1:0] {
    SRS_IDLE,
    SRS_HOLD,
    SRS_PLL,
    SRS_RUN
  } srs_state_type;

  typedef enum logic [1:0] {
    SRS_SRC_PWR,
    SRS_SRC_SW,
    SRS_SRC_DBG,
    SRS_SRC_WDT
  } srs_src_type;
endpackage

// ---- rtl/srs_pll_timer.sv ----
`timescale 1ns/1ps
module srs_pll_timer #(
  parameter int W = 18
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  srs_timer_if.timer tmr
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
    logic         done;
  } srs_tmr_type;

  srs_tmr_type s_r;
  srs_tmr_type s_nxt;

  // ----------------------------------------
  // Interval counter
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (tmr.start) begin
      s_nxt.cnt  = tmr.load;
      s_nxt.busy = 1'b1;
    end else if (s_r.busy) begin
      if (s_r.cnt <= W'(1)) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.cnt  = '0;
      end else begin
        s_nxt.cnt = s_r.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tmr.busy = s_r.busy;
  assign tmr.done = s_r.done;

  done_pulse_a: assert property (@(posedge clock_i) disable iff (rst_i)
    tmr.done |=> !tmr.done) else $error("timer done longer than one cycle");
endmodule

// ---- rtl/srs_regs.svh ----
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH

// Register offsets
`define SRS_CONFIG_OFS        12'hD72
`define SRS_STATUS_OFS        12'hD74
`define SRS_CORES_OFS         12'hD76

// Reset configuration fields
`define SRS_CFG_SWRST_BIT     0
`define SRS_CFG_GP_RST_BIT    1
`define SRS_CFG_DBG_RST_BIT   2
`define SRS_CFG_RESET         8'h00

// Reset source status fields
`define SRS_ST_PWR_BIT        0
`define SRS_ST_SW_BIT         1
`define SRS_ST_DBG_BIT        2
`define SRS_ST_WDT_BIT        3

// Timing
`define SRS_CLK_HZ            25000000
`define SRS_PLL_US            10000
`define SRS_PLL_CYC           ((`SRS_CLK_HZ / 1000000) * `SRS_PLL_US)

// Core defaults after system reset, one bit per core enable
`define SRS_CORE_DEFAULTS     16'h0347
`define SRS_CPU_MHZ           8'h64

`endif

// ---- rtl/srs_sequencer.sv ----
`timescale 1ns/1ps
`include "srs_regs.svh"
// Overview of operation
// - Power-good rise, software bit, debug reset or enabled watchdog timeout starts reset.
// - Reset event asserts CPU, register, expansion-bus and PCI resets.
// - Boot and board info pins latched at event end only for power-good.
// - Clock reset issued only if battery low and power-good was the source.
// - After event ends, wait PLL interval before releasing CPU, bus, PCI resets.
// - Expansion-bus and PCI reset outputs stay asserted through the whole interval.
// - Hard CPU reset restores CPU registers and invalidates cache.
// - Debug-entry bit set makes the CPU enter debug mode after reset.
// - CPU enabled at 100 MHz with registers and cache reset afterwards.
// - Arbiter nonconcurrent, only CPU enabled as bus master.
// - PCI bridge master enabled, target disabled.
// - Memory controller disabled, no banks, write and read buffers disabled.
// - ROM controller enabled with only boot chip select active.
// - Expansion bus disabled until region attribute registers are programmed.
// - Expansion DMA enabled with every channel masked.
// - Interrupt controller enabled, CPU interrupts masked, NMI disabled.
// - General-purpose timers disabled with registers cleared.
// - Interval timers, watchdog and UARTs disabled; serial port idle until commanded.
// - Programmable I/O pins default to input and I/O function.
// - PLL interval is 10 ms from end of reset source.
// - Per-source status flag set on event, cleared by writing one.
module srs_sequencer #(
  parameter int PLL_CYC = `SRS_PLL_CYC,
  parameter int TW      = 18
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Reset requests
  input  wire logic        board_power_ok_input_i,
  input  wire logic        debug_sys_reset_i,
  input  wire logic        wdt_timeout_i,
  input  wire logic        wdt_sysreset_en_i,
  input  wire logic        battery_low_i,
  // Register port
  input  wire logic [11:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  // Configuration pins
  input  wire logic [3:0]  boot_config_pins_i,
  input  wire logic [7:0]  board_info_pins_i,
  output logic [3:0]       boot_config_o,
  output logic [7:0]       board_info_o,
  // Reset outputs
  output logic             cpu_hard_reset_o,
  output logic             cache_invalidate_o,
  output logic             int_reg_reset_o,
  output logic             expansion_bus_reset_out_o,
  output logic             pci_reset_n_o,
  output logic             rtc_reset_o,
  output logic             debug_enter_o,
  output logic             pll_restart_o,
  // Core defaults
  output logic [15:0]      core_defaults_o,
  output logic [7:0]       cpu_clock_mhz_o,
  output srs_pkg::srs_state_type state_o
);
  import srs_pkg::*;

  typedef struct packed {
    srs_state_type state;
    logic          pwr_q;
    logic          from_pwr;
    logic [7:0]    cfg;
    logic [3:0]    status;
    logic [3:0]    boot;
    logic [7:0]    info;
    logic          rtc;
    logic          dbg;
    logic [15:0]   rdata;
  } srs_seq_type;

  srs_seq_type s_r;
  srs_seq_type s_nxt;

  srs_timer_if #(.W(TW)) tmr ();

  srs_pll_timer #(.W(TW)) u_timer (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tmr     (tmr.timer)
  );

  logic       pwr_rise;
  logic       sw_req;
  logic       any_req;
  logic [3:0] req_vec;
  logic       in_reset;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------
  // Request detection
  // ----------------------------------------
  assign pwr_rise = board_power_ok_input_i & ~s_r.pwr_q;
  assign sw_req   = reg_wr_i & hit(reg_addr_i, `SRS_CONFIG_OFS) & reg_wdata_i[`SRS_CFG_SWRST_BIT];
  assign req_vec  = {wdt_timeout_i & wdt_sysreset_en_i, debug_sys_reset_i, sw_req, pwr_rise};
  assign any_req  = |req_vec;
  assign in_reset = (s_r.state == SRS_HOLD) || (s_r.state == SRS_PLL);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    s_nxt        = s_r;
    s_nxt.pwr_q  = board_power_ok_input_i;
    s_nxt.rtc    = 1'b0;
    tmr.start    = 1'b0;
    tmr.load     = TW'(PLL_CYC);
    // Status: clear by writing one, set wins
    if (reg_wr_i && hit(reg_addr_i, `SRS_STATUS_OFS)) begin
      s_nxt.status = s_r.status & ~reg_wdata_i[3:0];
    end
    s_nxt.status = s_nxt.status | req_vec;
    if (reg_wr_i && hit(reg_addr_i, `SRS_CONFIG_OFS)) begin
      s_nxt.cfg = reg_wdata_i & ~(8'h01 << `SRS_CFG_SWRST_BIT);
    end
    case (s_r.state)
      SRS_IDLE, SRS_RUN: begin
        if (any_req) begin
          s_nxt.state    = SRS_HOLD;
          s_nxt.from_pwr = req_vec[SRS_SRC_PWR];
          s_nxt.dbg      = 1'b0;
        end
      end
      SRS_HOLD: begin
        if (any_req) begin
          s_nxt.from_pwr = s_r.from_pwr | req_vec[SRS_SRC_PWR];
        end else begin
          s_nxt.state = SRS_PLL;
          tmr.start   = 1'b1;
          if (s_r.from_pwr) begin
            s_nxt.boot = boot_config_pins_i;
            s_nxt.info = board_info_pins_i;
            s_nxt.rtc  = battery_low_i;
          end
        end
      end
      SRS_PLL: begin
        if (any_req) begin
          s_nxt.state    = SRS_HOLD;
          s_nxt.from_pwr = req_vec[SRS_SRC_PWR];
        end else if (tmr.done) begin
          s_nxt.state = SRS_RUN;
          s_nxt.dbg   = s_r.cfg[`SRS_CFG_DBG_RST_BIT];
        end
      end
      default: s_nxt.state = SRS_IDLE;
    endcase
    // Read data
    if (reg_rd_i && hit(reg_addr_i, `SRS_CONFIG_OFS)) begin
      s_nxt.rdata = {8'h00, s_r.cfg};
    end else if (reg_rd_i && hit(reg_addr_i, `SRS_STATUS_OFS)) begin
      s_nxt.rdata = {12'h000, s_r.status};
    end else if (reg_rd_i && hit(reg_addr_i, `SRS_CORES_OFS)) begin
      s_nxt.rdata = `SRS_CORE_DEFAULTS;
    end else if (reg_rd_i) begin
      s_nxt.rdata = 16'h0000;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_r       <= '0;
      s_r.cfg   <= `SRS_CFG_RESET;
      s_r.state <= SRS_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cpu_hard_reset_o          = in_reset;
  assign cache_invalidate_o        = in_reset;
  assign int_reg_reset_o           = s_r.state == SRS_HOLD;
  assign expansion_bus_reset_out_o = in_reset | s_r.cfg[`SRS_CFG_GP_RST_BIT];
  assign pci_reset_n_o             = ~in_reset;
  assign rtc_reset_o               = s_r.rtc;
  assign debug_enter_o             = s_r.dbg;
  assign pll_restart_o             = tmr.busy;
  assign boot_config_o             = s_r.boot;
  assign board_info_o              = s_r.info;
  assign reg_rdata_o               = s_r.rdata;
  assign state_o                   = s_r.state;
  // Bits: 0 cpu, 1 arbiter, 2 pci master, 3 pci target, 4 sdram, 5 buffers, 6 rom,
  // 7 exp bus, 8 dma, 9 pic, 10 gp timers, 11 pit, 12 wdt, 13 uart, 14 serial port, 15 io out
  assign core_defaults_o           = `SRS_CORE_DEFAULTS;
  assign cpu_clock_mhz_o           = `SRS_CPU_MHZ;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  req_enters_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    any_req |=> s_r.state == SRS_HOLD)
    else $error("request did not start reset");
  resets_asserted_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s_r.state == SRS_HOLD |-> cpu_hard_reset_o && int_reg_reset_o && !pci_reset_n_o)
    else $error("reset outputs not asserted");
  latch_pwr_only_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == SRS_HOLD && !any_req && !s_r.from_pwr) |=> $stable(boot_config_o))
    else $error("pins latched for non power reset");
  rtc_cond_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rtc_reset_o |-> $past(s_r.from_pwr) && $past(battery_low_i))
    else $error("rtc reset without cause");
  pll_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    tmr.start |=> cpu_hard_reset_o [*8])
    else $error("reset released early");
  bus_reset_pll_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s_r.state == SRS_PLL |-> expansion_bus_reset_out_o && !pci_reset_n_o)
    else $error("bus reset dropped in interval");
  debug_entry_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ($past(s_r.state) == SRS_PLL && s_r.state == SRS_RUN) |-> debug_enter_o == s_r.cfg[`SRS_CFG_DBG_RST_BIT])
    else $error("debug entry mismatch");
  status_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_vec[0] |=> s_r.status[0])
    else $error("status flag not set");
  restart_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == SRS_PLL && any_req) |=> s_r.state == SRS_HOLD)
    else $error("restart failed");
  cache_inv_a: assert property (@(posedge clock_i) disable iff (rst_i)
    cpu_hard_reset_o |-> cache_invalidate_o)
    else $error("cache not invalidated in reset");
  run_release_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s_r.state == SRS_RUN |-> !cpu_hard_reset_o && pci_reset_n_o)
    else $error("resets held after sequence");
  pll_release_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == SRS_PLL && tmr.done && !any_req) |=> s_r.state == SRS_RUN)
    else $error("release missed after interval");
  pll_wait_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == SRS_PLL && !tmr.done && !any_req) |=> s_r.state == SRS_PLL)
    else $error("interval cut short");
  timer_load_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == SRS_HOLD && !any_req) |=> s_r.state == SRS_PLL && tmr.busy)
    else $error("interval timer not started");
  timer_run_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == SRS_PLL && !tmr.done) |-> tmr.busy)
    else $error("timer idle during interval");
  restart_busy_a: assert property (@(posedge clock_i) disable iff (rst_i)
    tmr.start |=> pll_restart_o)
    else $error("restart flag missing");
  rtc_pulse_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rtc_reset_o |=> !rtc_reset_o)
    else $error("rtc reset longer than one cycle");
  rtc_phase_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rtc_reset_o |-> s_r.state == SRS_PLL)
    else $error("rtc reset outside interval");
  rtc_battery_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == SRS_HOLD && !any_req && s_r.from_pwr && battery_low_i) |=> rtc_reset_o)
    else $error("rtc reset missing for low battery");
  rtc_source_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == SRS_HOLD && !s_r.from_pwr) |=> !rtc_reset_o)
    else $error("rtc reset for non power source");
  latch_boot_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == SRS_HOLD && !any_req && s_r.from_pwr) |=> boot_config_o == $past(boot_config_pins_i))
    else $error("boot pins not latched");
  latch_info_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == SRS_HOLD && !any_req && s_r.from_pwr) |=> board_info_o == $past(board_info_pins_i))
    else $error("board info pins not latched");
  pwr_source_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ((s_r.state == SRS_IDLE || s_r.state == SRS_RUN) && pwr_rise) |=> s_r.from_pwr)
    else $error("power source not recorded");
  other_source_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ((s_r.state == SRS_IDLE || s_r.state == SRS_RUN) && any_req && !pwr_rise) |=> !s_r.from_pwr)
    else $error("power source recorded wrongly");
  debug_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ((s_r.state == SRS_IDLE || s_r.state == SRS_RUN) && any_req) |=> !debug_enter_o)
    else $error("debug entry kept over new reset");
  status_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (reg_wr_i && hit(reg_addr_i, `SRS_STATUS_OFS) && reg_wdata_i[0] && !pwr_rise) |=> !s_r.status[0])
    else $error("status flag not cleared");
  status_all_a: assert property (@(posedge clock_i) disable iff (rst_i)
    any_req |=> (s_r.status & $past(req_vec)) == $past(req_vec))
    else $error("source status flag not set");
  read_status_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (reg_rd_i && hit(reg_addr_i, `SRS_STATUS_OFS)) |=> reg_rdata_o == {12'h000, $past(s_r.status)})
    else $error("status read data wrong");
  swbit_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !s_r.cfg[`SRS_CFG_SWRST_BIT])
    else $error("software reset bit stored");
  wdt_gate_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (wdt_timeout_i && !wdt_sysreset_en_i) |-> !req_vec[SRS_SRC_WDT])
    else $error("disabled watchdog requested reset");
  run_stays_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == SRS_RUN && !any_req) |=> s_r.state == SRS_RUN)
    else $error("reset without request");
  exp_cfg_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s_r.cfg[`SRS_CFG_GP_RST_BIT] |-> expansion_bus_reset_out_o)
    else $error("expansion reset bit ignored");
  cfg_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (reg_wr_i && hit(reg_addr_i, `SRS_CONFIG_OFS)) |=> s_r.cfg == ($past(reg_wdata_i) & 8'hFE))
    else $error("configuration write lost");
endmodule

// ---- rtl/srs_timer_if.sv ----
`timescale 1ns/1ps
interface srs_timer_if #(parameter int W = 18);
  logic         start;
  logic         busy;
  logic         done;
  logic [W-1:0] load;
  modport ctrl  (output start, output load, input busy, input done);
  modport timer (input start, input load, output busy, output done);
endinterface

// ---- verif/srs_board_model.sv ----
`timescale 1ns/1ps
module srs_board_model (
  // Bench control
  input  wire logic        clock_i,
  input  wire logic        power_on_i,
  input  wire logic        batt_low_i,
  input  wire logic [11:0] pins_i,
  input  wire logic        in_reset_i,
  // Board side
  output logic             board_power_ok_o,
  output logic             battery_low_o,
  output logic [11:0]      pins_o,
  output logic             trst_n_o
);
  // ------------------------------------------------------------
  // Supervisor and straps
  // ------------------------------------------------------------
  assign trst_n_o = 1'b0;
  // Straps valid while reset is held or power is off, else bus traffic
  always @(negedge clock_i) begin
    board_power_ok_o <= power_on_i;
    battery_low_o <= batt_low_i;
    pins_o <= (in_reset_i || !power_on_i) ? pins_i : ~pins_o;
  end
endmodule

// ---- verif/system_reset_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`include "srs_regs.svh"
module system_reset_sequencer_tb_top;
  import srs_pkg::*;
  localparam int PC = 20;
  logic clock_i, rst_i, dbg, wdt, wdt_en, pwr_on, batt, wr, rd, rd_d, pok, blow;
  logic cpu, cinv, irr, exr, pcin, rtc, dben, pllr;
  logic [11:0] addr, pins, sp, pv;
  logic [7:0]  wd, bi, mhz;
  logic [3:0]  bc;
  logic [15:0] rdata, cores;
  srs_state_type st;
  logic [15:0] exp_q[$];
  int num_errors, n_tests;
  srs_board_model u_srs_board_model (.clock_i(clock_i), .power_on_i(pwr_on), .batt_low_i(batt),
    .pins_i(pins), .in_reset_i(cpu), .board_power_ok_o(pok), .battery_low_o(blow), .pins_o(pv), .trst_n_o());
  srs_sequencer #(.PLL_CYC(PC), .TW(18)) u_srs_sequencer (.clock_i(clock_i), .rst_i(rst_i),
    .board_power_ok_input_i(pok), .debug_sys_reset_i(dbg), .wdt_timeout_i(wdt), .wdt_sysreset_en_i(wdt_en),
    .battery_low_i(blow), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata),
    .boot_config_pins_i(pv[11:8]), .board_info_pins_i(pv[7:0]), .boot_config_o(bc), .board_info_o(bi),
    .cpu_hard_reset_o(cpu), .cache_invalidate_o(cinv), .int_reg_reset_o(irr), .expansion_bus_reset_out_o(exr),
    .pci_reset_n_o(pcin), .rtc_reset_o(rtc), .debug_enter_o(dben), .pll_restart_o(pllr),
    .core_defaults_o(cores), .cpu_clock_mhz_o(mhz), .state_o(st));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(string nm, logic [15:0] e, logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task chk_n(string nm, int e, int s);
    n_tests++;
    if (s != e) begin
      num_errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, s);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task wreg(logic [11:0] a, logic [7:0] d);
    @(negedge clock_i);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clock_i);
    wr = 1'b0;
  endtask
  task rreg(logic [11:0] a, logic [15:0] e);
    exp_q.push_back(e);
    @(negedge clock_i);
    addr = a;
    rd = 1'b1;
    @(negedge clock_i);
    rd = 1'b0;
    @(negedge clock_i);
  endtask
  task req(logic dv, logic wv);
    @(negedge clock_i);
    dbg = dv;
    wdt = wv;
    @(negedge clock_i);
    dbg = 1'b0;
    wdt = 1'b0;
  endtask
  task seq(int e_rtc);
    int h, c, p, x, r, k, q;
    h = 0; c = 0; p = 0; x = 0; r = 0; k = 0; q = 0;
    while (irr !== 1'b1 && k < 8) begin
      @(negedge clock_i);
      k++;
    end
    while (st !== SRS_RUN && k < 200) begin
      h += (irr === 1'b1);
      c += (cpu === 1'b1 && cinv === 1'b1);
      p += (pcin === 1'b0);
      x += (exr === 1'b1);
      r += (rtc === 1'b1);
      q += (pllr === 1'b1 && irr !== 1'b1);
      @(negedge clock_i);
      k++;
    end
    chk_n("pll_cycles", PC + 1, c - h);
    chk_n("pci_low", c, p);
    chk_n("exp_high", c, x);
    chk_n("rtc_pulses", e_rtc, r);
    chk_n("pll_busy", PC, q);
    chk("released", 16'h0001, {14'h0, cpu, pcin});
  endtask
  task pwr(logic b, logic [11:0] v);
    pins = v;
    batt = b;
    pwr_on = 1'b0;
    repeat (3) @(negedge clock_i);
    pwr_on <= 1'b1;
    seq(b);
    chk("pins", {4'h0, v}, {4'h0, bc, bi});
  endtask
  // ------------------------------------------------------------
  // Stimulus and monitor
  // ------------------------------------------------------------
  always @(posedge clock_i) rd_d <= rd;
  always @(negedge clock_i) if (rd_d === 1'b1) chk("rdata", exp_q.pop_front(), rdata);
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    #(40 * 4000);
    num_errors++;
    conclude;
  end
  initial begin
    rst_i = 1'b1; dbg = 1'b0; wdt = 1'b0; wdt_en = 1'b0; pwr_on = 1'b0; batt = 1'b0;
    wr = 1'b0; rd = 1'b0; addr = 12'h000; wd = 8'h00; pins = 12'h000;
    num_errors = 0; n_tests = 0;
    void'($urandom(32'h5870218A));
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    sp = 12'($urandom);
    pwr(1'b1, sp);
    chk("cores", 16'h0347, cores);
    chk("cpu_mhz", 16'h0064, {8'h00, mhz});
    rreg(`SRS_STATUS_OFS, 16'h0001);
    wreg(`SRS_STATUS_OFS, 8'h0F);
    rreg(`SRS_STATUS_OFS, 16'h0000);
    wreg(`SRS_CORES_OFS, 8'hFF);
    rreg(`SRS_CORES_OFS, 16'h0347);
    rreg(12'h123, 16'h0000);
    $display("test power_good done");
    pins = ~sp;
    wreg(`SRS_CONFIG_OFS, 8'h01);
    seq(0);
    chk("pins_kept", {4'h0, sp}, {4'h0, bc, bi});
    rreg(`SRS_STATUS_OFS, 16'h0002);
    rreg(`SRS_CONFIG_OFS, 16'h0000);
    wreg(`SRS_STATUS_OFS, 8'h0F);
    $display("test software done");
    wreg(`SRS_CONFIG_OFS, 8'h04);
    req(1'b1, 1'b0);
    seq(0);
    chk("dbg_enter", 16'h0001, {15'h0, dben});
    rreg(`SRS_STATUS_OFS, 16'h0004);
    req(1'b1, 1'b0);
    repeat (8) @(negedge clock_i);
    chk("dbg_clear", 16'h0000, {15'h0, dben});
    req(1'b1, 1'b0);
    seq(0);
    wreg(`SRS_CONFIG_OFS, 8'h00);
    wreg(`SRS_STATUS_OFS, 8'h0F);
    $display("test debug done");
    req(1'b0, 1'b1);
    repeat (3) @(negedge clock_i);
    chk("wdt_off", 16'(SRS_RUN), 16'(st));
    wdt_en = 1'b1;
    req(1'b0, 1'b1);
    seq(0);
    rreg(`SRS_STATUS_OFS, 16'h0008);
    $display("test watchdog done");
    wreg(`SRS_CONFIG_OFS, 8'h02);
    chk("exp_sw", 16'h0001, {15'h0, exr});
    rreg(`SRS_CONFIG_OFS, 16'h0002);
    wreg(`SRS_CONFIG_OFS, 8'h00);
    chk("exp_sw_off", 16'h0000, {15'h0, exr});
    sp = 12'($urandom);
    pwr(1'b0, sp);
    $display("test second_power done");
    conclude;
  end
endmodule
